// ---- shared/ocm_pkg.sv ----
/*
  shared constants and carrier types for the on-chip memory controller:
  widths, limits, status bit positions, state encoding and port structs.
  assumes: included first in compile order by every design file.
*/
package ocm_pkg;

  // ==========================================================
  // widths and counts
  localparam int OCM_DW = 128;          // main data word width
  localparam int OCM_BEW = 16;          // byte enables per word
  localparam int OCM_CW = 9;            // stored check code width
  localparam int OCM_AW = 32;           // byte address width
  localparam int OCM_NCB = 12;          // number of circular buffers
  localparam int OCM_HIST = 4;          // depth of each error history
  localparam int OCM_CNTW = 16;         // error counter width
  localparam int OCM_OFFW = 23;         // frame offset width (8 MiB)
  localparam int OCM_DEPTH = 4096;      // default words of storage

  // ==========================================================
  // limits and byte sizes
  localparam logic [31:0] OCM_VFRAME_MAX = 32'h0080_0000;  // 8 MiB
  localparam logic [31:0] OCM_CIRCULAR_FRAME_BUFFER_MAX = 32'h0010_0000;    // 1 MiB
  localparam logic [22:0] OCM_BEAT_BYTES = 23'h00_0010;    // one word
  localparam logic [15:0] OCM_BE_FULL = 16'hffff;
  localparam logic [15:0] OCM_CNT_MAX = 16'hffff;

  // ==========================================================
  // sticky status bit positions
  localparam int OCM_SB_SEC = 0;
  localparam int OCM_SB_DED = 1;
  localparam int OCM_SB_AEE = 2;
  localparam int OCM_SB_THR = 3;        // three threshold bits 3..5
  localparam int OCM_SB_ILL = 6;
  localparam int OCM_SB_OVF = 7;
  localparam int OCM_SB_UNF = 8;
  localparam int OCM_NSTAT = 9;
  localparam int OCM_NECC = 6;          // bits 0..5 are the ecc group

  // interrupt routing choice per output
  localparam logic OCM_INT_ECC = 1'b0;
  localparam logic OCM_INT_CIRCULAR_FRAME_BUFFER = 1'b1;

  // ==========================================================
  // types
  typedef enum logic [0:0] {
    OCM_ST_IDLE = 1'b0,
    OCM_ST_RMW = 1'b1
  } ocm_state_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [15:0] be;
    logic [127:0] wdata;
  } ocm_req_t;

  typedef struct packed {
    logic ecc_en;
    logic diag_en;
    logic [1:0] int_sel;
    logic [2:0][15:0] thr;              // 0 single, 1 double, 2 address
  } ocm_ctl_t;

  typedef struct packed {
    logic en;
    logic [31:0] vbase;
    logic [31:0] vsize;
    logic [31:0] bbase;
    logic [31:0] bsize;
  } ocm_circular_frame_buffer_cfg_t;

  typedef struct packed {
    logic unf;
    logic ovf;
    logic ill;
    logic [2:0] thr;
    logic aee;
    logic ded;
    logic sec;
  } ocm_stat_t;

endpackage

// ---- logic/ocm_ecc_codec.sv ----
/*
  secded hamming codec over a data word joined with its word address.
  eight position bits plus one overall parity bit form the check code.
  assumes: purely combinational, instanced once to decode and once to encode.
*/
module ocm_ecc_codec #(
  parameter int DW = 128,
  parameter int AW = 12
) (
  input wire logic [DW-1:0] data_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [8:0] chk_i,
  output logic [8:0] chk_o,
  output logic [DW-1:0] data_o,
  output logic sec_o,
  output logic ded_o,
  output logic aee_o
);
  import ocm_pkg::*;

  localparam int KW = DW + AW;          // protected bits incl address

  // ==========================================================
  // position arithmetic
  // xor of hamming positions of all set bits, powers of two skipped
  function automatic logic [7:0] ham(input logic [KW-1:0] v);
    logic [7:0] h;
    int k;
    h = 8'h00;
    k = 0;
    for (int p = 3; p < 256; p++) begin
      if ((p & (p - 1)) != 0 && k < KW) begin
        if (v[k]) h = h ^ 8'(p);
        k++;
      end
    end
    return h;
  endfunction

  // bit index for a syndrome, -1 when no protected bit sits there
  function automatic int locate(input logic [7:0] s);
    int k;
    int r;
    k = 0;
    r = -1;
    for (int p = 3; p < 256; p++) begin
      if ((p & (p - 1)) != 0 && k < KW) begin
        if (8'(p) == s) r = k;
        k++;
      end
    end
    return r;
  endfunction

  logic [KW-1:0] word;                  // address joined to data
  logic [7:0] h;                        // recomputed position bits
  logic [7:0] syn;                      // syndrome
  logic par;                            // overall parity mismatch
  int idx;                              // located bit

  // encoder: address takes part so a wrong-word read is caught
  always_comb begin
    word = {addr_i, data_i};
    h = ham(word);
    chk_o = {(^word) ^ (^h), h};
  end

  // decoder: single errors fixed, double and address errors flagged
  always_comb begin
    syn = h ^ chk_i[7:0];
    par = (^word) ^ (^chk_i);
    idx = locate(syn);
    data_o = data_i;
    sec_o = 1'b0;
    ded_o = 1'b0;
    aee_o = 1'b0;
    if (par) begin
      if ((syn & (syn - 8'h01)) == 8'h00) begin
        sec_o = 1'b1;                   // a check bit flipped, data fine
      end else if (idx < 0) begin
        ded_o = 1'b1;                   // points nowhere: multi-bit
      end else if (idx < DW) begin
        sec_o = 1'b1;
        data_o[idx] = ~data_i[idx];
      end else begin
        aee_o = 1'b1;                   // stored for another address
      end
    end else if (syn != 8'h00) begin
      ded_o = 1'b1;
    end
  end

endmodule

// ---- logic/ocm_ctrl.sv ----
/*
  on-chip sram controller: 128-bit data port with secded protection,
  error histories, diagnostic counters and circular buffer translation.
  assumes: one clock; the configuration side is modelled by plain ports
  that are sampled on a half-rate enable; inputs are synchronous.
*/
// Behaviour
// - 128-bit data port, one beat per cycle
// - config port single 32-bit accesses only
// - config side runs at half rate
// - 9-bit secded over data and address
// - control bit enables error checking
// - single errors corrected on reads
// - every write stores fresh check code
// - partial writes use read-modify-write
// - four-entry history of corrected addresses
// - repeated corrected address not stored again
// - four-entry history of uncorrectable addresses
// - flag correctable and uncorrectable errors
// - count single, double and address errors
// - counter reaching threshold raises exception
// - diagnostics switchable on and off
// - settings and status only on config side
// - twelve circular buffers with own ranges
// - translation adds no latency
// - frames to 8 MiB, buffers 1 MiB
// - illegal buffer access flagged as error
// - overflow, underflow and last addresses kept
// - two interrupts each routed ecc or buffer
module ocm_ctrl #(
  parameter int DEPTH = ocm_pkg::OCM_DEPTH,
  parameter int NCB = ocm_pkg::OCM_NCB
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire ocm_pkg::ocm_req_t REQ_I,
  output logic READY_O,
  output logic RVALID_O,
  output logic [127:0] RDATA_O,
  output logic RERR_O,
  input wire ocm_pkg::ocm_ctl_t CTL_I,
  input wire ocm_pkg::ocm_circular_frame_buffer_cfg_t CB_CFG_I [NCB],
  input wire logic [8:0] STAT_CLR_I,
  input wire logic SEC_POP_I,
  input wire logic UNC_POP_I,
  output ocm_pkg::ocm_stat_t STAT_O,
  output logic [2:0][15:0] CNT_O,
  output logic [31:0] SEC_HEAD_O,
  output logic [2:0] SEC_LVL_O,
  output logic [31:0] UNC_HEAD_O,
  output logic [2:0] UNC_LVL_O,
  output logic [31:0] LAST_RD_ADDR_O,
  output logic [31:0] LAST_WR_ADDR_O,
  output logic [1:0] INT_O
);
  import ocm_pkg::*;

  localparam int WAW = $clog2(DEPTH);

  // ==========================================================
  // storage and state
  logic [OCM_DW+OCM_CW-1:0] mem [DEPTH];   // data with check code
  logic cfg_en_q;                         // half-rate config enable
  ocm_ctl_t ctl_q;
  ocm_circular_frame_buffer_cfg_t cb_q [NCB];
  ocm_state_t state_q;
  logic ready_q;
  logic s1_vld_q, s1_rmw_q, s1_err_q;     // stage after array read
  logic [WAW-1:0] s1_word_q;
  logic [OCM_DW+OCM_CW-1:0] s1_raw_q;
  logic [15:0] s1_be_q;
  logic [127:0] s1_wdata_q;
  logic [OCM_NSTAT-1:0] stat_q;
  logic [2:0][15:0] cnt_q;
  logic [31:0] hist_q [2][OCM_HIST];      // 0 corrected, 1 uncorrectable
  logic [2:0] lvl_q [2];
  logic [OCM_OFFW-1:0] wr_end_q [NCB];    // frame end written so far
  logic [OCM_OFFW-1:0] rd_end_q [NCB];    // frame end read so far
  logic [31:0] last_rd_q, last_wr_q;
  logic rvalid_q, rerr_q;
  logic [127:0] rdata_q;
  logic [1:0] int_q;

  // ==========================================================
  // configuration capture
  // the config side is slower; pulses on it last two fast cycles, so
  // every config action is taken only on the enable
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) cfg_en_q <= 1'b0;
    else cfg_en_q <= ~cfg_en_q;
  end

  // single-word settings sampled once per config cycle
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ctl_q <= '0;
      for (int i = 0; i < NCB; i++) cb_q[i] <= '0;
    end else if (cfg_en_q) begin
      ctl_q <= CTL_I;
      for (int i = 0; i < NCB; i++) cb_q[i] <= CB_CFG_I[i];
    end
  end

  // ==========================================================
  // circular buffer translation
  function automatic logic cfg_bad(input ocm_circular_frame_buffer_cfg_t c);
    return c.vsize > OCM_VFRAME_MAX || c.bsize > OCM_CIRCULAR_FRAME_BUFFER_MAX ||
           c.bsize == 32'h0000_0000 || (c.bsize & (c.bsize - 32'h1)) != 32'h0;
  endfunction

  logic acc, cb_hit, cb_bad, cb_ovf, cb_unf, partial;
  logic [3:0] cb_idx;
  logic [OCM_OFFW-1:0] off, off_end;
  logic [31:0] phys;
  logic [WAW-1:0] word0;

  // same-cycle window match; no register on the path
  always_comb begin
    acc = REQ_I.valid && ready_q;
    phys = REQ_I.addr;
    cb_hit = 1'b0;
    cb_bad = 1'b0;
    cb_idx = 4'h0;
    off = '0;
    for (int i = 0; i < NCB; i++) begin
      if (cb_q[i].en && REQ_I.addr >= cb_q[i].vbase &&
          REQ_I.addr - cb_q[i].vbase < cb_q[i].vsize) begin
        cb_hit = 1'b1;
        cb_idx = 4'(i);
        cb_bad = cfg_bad(cb_q[i]);
        off = OCM_OFFW'(REQ_I.addr - cb_q[i].vbase);
        phys = cb_q[i].bbase + ({9'h000, off} & (cb_q[i].bsize - 32'h1));
      end
    end
    off_end = off + OCM_BEAT_BYTES;
    // frame restart at offset zero never counts as overrun
    cb_ovf = cb_hit && REQ_I.we && off != '0 &&
             {1'b0, off_end} > {1'b0, rd_end_q[cb_idx]} + cb_q[cb_idx].bsize[23:0];
    cb_unf = cb_hit && !REQ_I.we && off_end > wr_end_q[cb_idx];
    word0 = phys[4 +: WAW];
    partial = REQ_I.be != OCM_BE_FULL;
  end

  wire logic rej = cb_hit && (cb_bad || cb_ovf || cb_unf);

  // ==========================================================
  // ecc codecs
  logic [OCM_CW-1:0] enc_chk;
  logic [127:0] dec_data, merged, enc_data;
  logic dec_sec, dec_ded, dec_aee;
  logic [WAW-1:0] enc_word;

  // byte merge of new data over the corrected old word
  always_comb begin
    for (int b = 0; b < OCM_BEW; b++) begin
      merged[b*8 +: 8] = s1_be_q[b] ? s1_wdata_q[b*8 +: 8] : dec_data[b*8 +: 8];
    end
    enc_data = (state_q == OCM_ST_RMW) ? merged : REQ_I.wdata;
    enc_word = (state_q == OCM_ST_RMW) ? s1_word_q : word0;
  end

  ocm_ecc_codec #(.DW(OCM_DW), .AW(WAW)) u_dec (
    .data_i(s1_raw_q[127:0]),
    .addr_i(s1_word_q),
    .chk_i(s1_raw_q[136:128]),
    .chk_o(),
    .data_o(dec_data),
    .sec_o(dec_sec),
    .ded_o(dec_ded),
    .aee_o(dec_aee)
  );

  ocm_ecc_codec #(.DW(OCM_DW), .AW(WAW)) u_enc (
    .data_i(enc_data),
    .addr_i(enc_word),
    .chk_i(9'h000),
    .chk_o(enc_chk),
    .data_o(),
    .sec_o(),
    .ded_o(),
    .aee_o()
  );

  // checks only act when protection is on; codes are always stored
  wire logic chk_on = s1_vld_q && !s1_err_q && ctl_q.ecc_en;
  wire logic ev_sec = chk_on && dec_sec;
  wire logic ev_ded = chk_on && dec_ded;
  wire logic ev_aee = chk_on && dec_aee;
  wire logic [31:0] s1_addr = 32'({s1_word_q, 4'h0});

  // ==========================================================
  // data port sequencing
  // one access per cycle while ready; a partial write holds ready low
  // for one cycle to do its write half
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_q <= OCM_ST_IDLE;
      ready_q <= 1'b0;
    end else if (state_q == OCM_ST_RMW) begin
      state_q <= OCM_ST_IDLE;
      ready_q <= 1'b1;
    end else if (acc && REQ_I.we && partial && !rej) begin
      state_q <= OCM_ST_RMW;
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // array read stage and array writes
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      s1_vld_q <= 1'b0;
      s1_rmw_q <= 1'b0;
      s1_err_q <= 1'b0;
    end else begin
      // a refused partial write has no read half, so it must not answer
      s1_vld_q <= acc && (!REQ_I.we || (partial && !rej));
      s1_rmw_q <= acc && REQ_I.we && partial && !rej;
      s1_err_q <= rej;
    end
    if (acc) begin
      s1_word_q <= word0;
      s1_be_q <= REQ_I.be;
      s1_wdata_q <= REQ_I.wdata;
      s1_raw_q <= mem[word0];
    end
    if (state_q == OCM_ST_RMW) begin
      mem[s1_word_q] <= {enc_chk, merged};
    end else if (acc && REQ_I.we && !partial && !rej) begin
      mem[word0] <= {enc_chk, REQ_I.wdata};
    end
  end

  // read answer two edges after acceptance
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      rvalid_q <= 1'b0;
      rerr_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      rvalid_q <= s1_vld_q && !s1_rmw_q;
      rerr_q <= s1_vld_q && !s1_rmw_q && (s1_err_q || ev_ded || ev_aee);
      rdata_q <= ctl_q.ecc_en ? dec_data : s1_raw_q[127:0];
    end
  end

  // ==========================================================
  // buffer progress and last addresses
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      last_rd_q <= '0;
      last_wr_q <= '0;
      for (int i = 0; i < NCB; i++) begin
        wr_end_q[i] <= '0;
        rd_end_q[i] <= '0;
      end
    end else if (acc) begin
      if (REQ_I.we) last_wr_q <= REQ_I.addr;
      else last_rd_q <= REQ_I.addr;
      if (cb_hit && !rej && REQ_I.we) begin
        wr_end_q[cb_idx] <= off_end;
        if (off == '0) rd_end_q[cb_idx] <= '0;  // new frame
      end else if (cb_hit && !rej) begin
        rd_end_q[cb_idx] <= off_end;
      end
    end
  end

  // ==========================================================
  // error histories
  logic [31:0] hist_d [2][OCM_HIST];
  logic [2:0] lvl_d [2];
  logic dup;
  logic [1:0] push, pop;

  // shift-register queues, head at entry zero
  always_comb begin
    dup = 1'b0;
    for (int i = 0; i < OCM_HIST; i++) begin
      if (3'(i) < lvl_q[0] && hist_q[0][i] == s1_addr) dup = 1'b1;
    end
    push[0] = ev_sec && !dup;
    push[1] = ev_ded || ev_aee;
    pop[0] = SEC_POP_I && cfg_en_q;
    pop[1] = UNC_POP_I && cfg_en_q;
    for (int f = 0; f < 2; f++) begin
      hist_d[f] = hist_q[f];
      lvl_d[f] = lvl_q[f];
      if (pop[f] && lvl_d[f] != 3'h0) begin
        for (int i = 0; i < OCM_HIST - 1; i++) hist_d[f][i] = hist_q[f][i+1];
        lvl_d[f] = lvl_d[f] - 3'h1;
      end
      if (push[f] && lvl_d[f] < 3'(OCM_HIST)) begin  // full: newest dropped
        hist_d[f][lvl_d[f][1:0]] = s1_addr;
        lvl_d[f] = lvl_d[f] + 3'h1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      for (int f = 0; f < 2; f++) begin
        lvl_q[f] <= 3'h0;
        for (int i = 0; i < OCM_HIST; i++) hist_q[f][i] <= '0;
      end
    end else begin
      hist_q <= hist_d;
      lvl_q <= lvl_d;
    end
  end

  // ==========================================================
  // diagnostic counters, sticky status and interrupt routing
  logic [2:0] ev;
  logic [2:0] thr_hit;
  logic [OCM_NSTAT-1:0] set_v;

  always_comb begin
    ev = {ev_aee, ev_ded, ev_sec};
    for (int c = 0; c < 3; c++) begin
      thr_hit[c] = ctl_q.diag_en && ev[c] && ctl_q.thr[c] != 16'h0000 &&
                   cnt_q[c] + 16'h0001 >= ctl_q.thr[c];
    end
    set_v = {rej && cb_unf, rej && cb_ovf, rej && cb_bad, thr_hit, ev};
  end

  // counters saturate rather than wrap, so a threshold is never missed
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) cnt_q <= '0;
    else if (ctl_q.diag_en) begin
      for (int c = 0; c < 3; c++) begin
        if (ev[c] && cnt_q[c] != OCM_CNT_MAX) cnt_q[c] <= cnt_q[c] + 16'h0001;
      end
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) stat_q <= '0;
    else stat_q <= (stat_q & ~(cfg_en_q ? STAT_CLR_I : 9'h000)) | (acc ? set_v : {3'h0, set_v[5:0]});
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) int_q <= 2'h0;
    else begin
      for (int n = 0; n < 2; n++) begin
        int_q[n] <= (ctl_q.int_sel[n] == OCM_INT_CIRCULAR_FRAME_BUFFER) ? |stat_q[8:6] : |stat_q[5:0];
      end
    end
  end

  // outputs, all from flip-flops
  assign READY_O = ready_q;
  assign RVALID_O = rvalid_q;
  assign RDATA_O = rdata_q;
  assign RERR_O = rerr_q;
  assign STAT_O = ocm_stat_t'(stat_q);
  assign CNT_O = cnt_q;
  assign SEC_HEAD_O = hist_q[0][0];
  assign SEC_LVL_O = lvl_q[0];
  assign UNC_HEAD_O = hist_q[1][0];
  assign UNC_LVL_O = lvl_q[1];
  assign LAST_RD_ADDR_O = last_rd_q;
  assign LAST_WR_ADDR_O = last_wr_q;
  assign INT_O = int_q;

  // ==========================================================
  // assertions
  a_cfg_half_rate: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    cfg_en_q |=> !cfg_en_q) else $error("config enable ran faster than half rate");
  a_read_answer: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    acc && !REQ_I.we |-> ##2 RVALID_O) else $error("read answer not two cycles later");
  a_write_silent: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    acc && REQ_I.we |-> ##2 !RVALID_O) else $error("write produced a read answer");
  a_rmw_stall: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    acc && REQ_I.we && partial && !rej |=> !READY_O ##1 READY_O)
    else $error("partial write did not stall exactly one cycle");
  a_sec_fix: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ev_sec && !s1_rmw_q |=> RVALID_O && RDATA_O == $past(dec_data))
    else $error("corrected data not returned");
  a_hist_nodup: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    lvl_q[0] >= 3'h2 |-> hist_q[0][0] != hist_q[0][1]) else $error("duplicate corrected address");
  a_hist_depth: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    lvl_q[0] <= 3'h4 && lvl_q[1] <= 3'h4) else $error("history deeper than four");
  a_unc_push: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ev_ded && lvl_q[1] < 3'h4 && !pop[1] |=> lvl_q[1] == $past(lvl_q[1]) + 3'h1)
    else $error("uncorrectable address not recorded");
  a_cnt_step: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ev_sec && ctl_q.diag_en && cnt_q[0] != OCM_CNT_MAX |=> cnt_q[0] == $past(cnt_q[0]) + 16'h1)
    else $error("single error count did not step");
  a_diag_off: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !ctl_q.diag_en |=> $stable(cnt_q)) else $error("counter moved with diagnostics off");
  a_thr_flag: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    thr_hit[1] |=> STAT_O.thr[1]) else $error("threshold reached without exception");
  a_illegal_flag: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    acc && cb_hit && cb_bad |=> STAT_O.ill) else $error("illegal buffer access not flagged");
  a_int_route: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ctl_q.int_sel[0] == OCM_INT_ECC && |stat_q[5:0] && $stable(ctl_q) |=> INT_O[0])
    else $error("ecc event not routed to interrupt zero");

endmodule

// ---- verification/ocm_init_model.sv ----
/*
  initiator model on the 128-bit data port of the on-chip memory controller.
  assumes: called from the bench, drives at falling edges, one clock.
*/
module ocm_init_model
  import ocm_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic rvalid_i,
  input wire logic [127:0] rdata_i,
  input wire logic rerr_i,
  output ocm_pkg::ocm_req_t req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req_o = '0;

  // ==========================================================
  // one whole 128-bit beat, held until ready is seen at a rising edge
  task automatic beat(input logic we, input logic [31:0] a, input logic [15:0] be,
                      input logic [127:0] d);
    @(negedge clk_i);
    req_o <= '{valid: 1'b1, we: we, addr: a, be: be, wdata: d};
    // ready comes from a flop: its level at a falling edge is what the next rising edge sees
    while (ready_i !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    @(negedge clk_i);
    // released lines show the inverse, so a stale value is never mistaken for a request
    req_o <= '{valid: 1'b0, we: ~we, addr: ~a, be: ~be, wdata: ~d};
  endtask

  // ==========================================================
  // read beat; the answer is waited for under a bounded count
  task automatic rd(input logic [31:0] a, output logic [127:0] d, output logic e);
    int n;
    beat(1'b0, a, OCM_BE_FULL, '0);
    n = 0;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    d = (rvalid_i === 1'b1) ? rdata_i : 'x; // no answer gives unknown data
    e = (rvalid_i === 1'b1) ? rerr_i : 1'bx;
  endtask
endmodule

// ---- verification/tb_top.sv ----
/*
  self-checking bench for the on-chip memory controller: data beats,
  read-modify-write, circular buffer translation, status and interrupts.
  assumes: the initiator model drives the data port; config ports are plain.
*/
module tb_top;
  import ocm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // signals
  logic clk;
  logic rst_b;
  ocm_req_t req;
  logic ready, rvalid, rerr;
  logic [127:0] rdata;
  ocm_ctl_t ctl;
  ocm_circular_frame_buffer_cfg_t cb [OCM_NCB];
  logic [8:0] stat_clr;
  ocm_stat_t stat;
  logic [2:0][15:0] cnt;
  logic [31:0] sec_head, unc_head, last_rd, last_wr;
  logic [2:0] sec_lvl, unc_lvl;
  logic [1:0] irq;
  logic sec_pop, unc_pop;
  int err_count = 0;
  int cmp_count = 0;
  logic [127:0] d;
  logic e;
  localparam logic [31:0] VB = 32'h1000_0000; // frame base of buffer 0

  always #10 clk = ~clk;

  ocm_ctrl i_dut (.CLK_I(clk), .RST_B_I(rst_b), .REQ_I(req), .READY_O(ready),
    .RVALID_O(rvalid), .RDATA_O(rdata), .RERR_O(rerr), .CTL_I(ctl), .CB_CFG_I(cb),
    .STAT_CLR_I(stat_clr), .SEC_POP_I(sec_pop), .UNC_POP_I(unc_pop), .STAT_O(stat),
    .CNT_O(cnt), .SEC_HEAD_O(sec_head), .SEC_LVL_O(sec_lvl), .UNC_HEAD_O(unc_head),
    .UNC_LVL_O(unc_lvl), .LAST_RD_ADDR_O(last_rd), .LAST_WR_ADDR_O(last_wr),
    .INT_O(irq));

  ocm_init_model i_mst (.clk_i(clk), .ready_i(ready), .rvalid_i(rvalid),
    .rdata_i(rdata), .rerr_i(rerr), .req_o(req));

  // ==========================================================
  // compare tasks and the single closing point
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic chk128(input logic [127:0] g, input logic [127:0] x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    #100us;
    err_count++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    ctl = '0;
    stat_clr = '0;
    sec_pop = 1'b0;
    unc_pop = 1'b0;
    foreach (cb[i]) cb[i] = '0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk({stat, sec_lvl, unc_lvl}, 32'h0);
    chk128({80'h0, cnt}, 128'h0);
    // buffer 0 legal (64 bytes), buffer 1 has a size that is not a power of two
    ctl.ecc_en = 1'b1;
    ctl.diag_en = 1'b1;
    ctl.int_sel = 2'b10;
    cb[0] = '{en: 1'b1, vbase: VB, vsize: 32'h100, bbase: 32'h8000, bsize: 32'h40};
    cb[1] = '{en: 1'b1, vbase: 32'h2000_0000, vsize: 32'h100, bbase: 32'h9000,
              bsize: 32'h30};
    repeat (4) @(negedge clk);
    // full word then a narrow write merged into it
    i_mst.beat(1'b1, 32'h100, OCM_BE_FULL, {4{32'hc0de_0001}});
    i_mst.rd(32'h100, d, e);
    chk128(d, {4{32'hc0de_0001}});
    chk(e, 1'b0);
    i_mst.beat(1'b1, 32'h100, 16'h000f, {4{32'h5a5a_a5a5}});
    chk(ready, 1'b0);
    i_mst.rd(32'h100, d, e);
    chk128(d, {{3{32'hc0de_0001}}, 32'h5a5a_a5a5});
    // frame writes land in the buffer without a wait state
    i_mst.beat(1'b1, VB, OCM_BE_FULL, {4{32'haaaa_0000}});
    i_mst.beat(1'b1, VB + 32'h10, OCM_BE_FULL, {4{32'hbbbb_0010}});
    chk(last_wr, VB + 32'h10);
    i_mst.rd(32'h8000, d, e);
    chk128(d, {4{32'haaaa_0000}});
    i_mst.rd(VB + 32'h10, d, e);
    chk128(d, {4{32'hbbbb_0010}});
    chk(last_rd, VB + 32'h10);
    // offset 0x50 wraps onto the second word of the buffer
    i_mst.beat(1'b1, VB + 32'h50, OCM_BE_FULL, {4{32'hdddd_0050}});
    i_mst.rd(32'h8010, d, e);
    chk128(d, {4{32'hdddd_0050}});
    // writing past read progress plus buffer size is an overflow
    // a narrow write is used so the refused path must also skip its read half
    i_mst.beat(1'b1, VB + 32'h70, 16'h00ff, '0);
    repeat (2) @(negedge clk);
    chk(stat, 9'h080);
    i_mst.rd(VB + 32'h90, d, e);
    chk(e, 1'b1);
    i_mst.rd(32'h2000_0000, d, e);
    chk(e, 1'b1);
    repeat (3) @(negedge clk);
    chk(stat, 9'h1c0);
    chk(irq, 2'b10);
    ctl.int_sel = 2'b01;
    repeat (4) @(negedge clk);
    chk(irq, 2'b01);
    // clear mask held for two cycles
    stat_clr = 9'h1c0;
    repeat (2) @(negedge clk);
    stat_clr = '0;
    repeat (2) @(negedge clk);
    chk(stat, 9'h000);
    // pops on empty histories are ignored and leave both queues empty
    sec_pop = 1'b1;
    unc_pop = 1'b1;
    repeat (2) @(negedge clk);
    sec_pop = 1'b0;
    unc_pop = 1'b0;
    @(negedge clk);
    chk({sec_lvl, unc_lvl, sec_head[3:0], unc_head[3:0]}, 32'h0);
    finish_test();
  end
endmodule
